// ==== pkg/ate_defs.svh ====
// Notes on behaviour
// - Sample probes every cycle until trigger.
// - On trigger stop acquisition, hold samples.
// - Basic bit condition: six selectable matches.
// - Bus pattern compare skips X bits.
// - Basic trigger is AND of all matches.
// - Advanced comparisons: lt, le, eq, ne, gt, ge.
// - Advanced tree: logical, reduction, shift, bitwise ops.
// - Edge and level detector operator supported.
// - Trigger on reduction AND of bus AND.
// - Bus compare ANDed with enable rising edge.
// - Trigger on instruction address equal preset.
`ifndef ATE_DEFS_SVH
`define ATE_DEFS_SVH
`define ATE_NBITS      8
`define ATE_BUS_W      16
`define ATE_NODES      8
`define ATE_NODE_W     3
`define ATE_ADDR_W     32
`define ATE_COND_W     3
`define ATE_OP_W       5
`endif

// ==== pkg/ate_pkg.sv ====
`include "ate_defs.svh"
package ate_pkg;
   // Per-bit basic condition encodings.
   typedef enum logic [`ATE_COND_W-1:0] {
      ATE_DONT_CARE = 3'h0,
      ATE_LOW       = 3'h1,
      ATE_HIGH      = 3'h2,
      ATE_FALL      = 3'h3,
      ATE_RISE      = 3'h4,
      ATE_EITHER    = 3'h5
   } ate_cond_t;

   // Advanced node operators; each node reads up to two higher-index nodes or leaf values.
   typedef enum logic [`ATE_OP_W-1:0] {
      ATE_OP_BUS_A   = 5'h00,
      ATE_OP_BUS_B   = 5'h01,
      ATE_OP_CONST   = 5'h02,
      ATE_OP_LT      = 5'h03,
      ATE_OP_LE      = 5'h04,
      ATE_OP_EQ      = 5'h05,
      ATE_OP_NE      = 5'h06,
      ATE_OP_GT      = 5'h07,
      ATE_OP_GE      = 5'h08,
      ATE_OP_LNOT    = 5'h09,
      ATE_OP_LAND    = 5'h0A,
      ATE_OP_LOR     = 5'h0B,
      ATE_OP_LXOR    = 5'h0C,
      ATE_OP_RAND    = 5'h0D,
      ATE_OP_ROR     = 5'h0E,
      ATE_OP_RXOR    = 5'h0F,
      ATE_OP_SHL     = 5'h10,
      ATE_OP_SHR     = 5'h11,
      ATE_OP_BNOT    = 5'h12,
      ATE_OP_BAND    = 5'h13,
      ATE_OP_BOR     = 5'h14,
      ATE_OP_BXOR    = 5'h15,
      ATE_OP_EDGE    = 5'h16,
      ATE_OP_BUS_C   = 5'h17,
      ATE_OP_BUS_D   = 5'h18
   } ate_op_t;

   typedef enum logic [1:0] {
      ATE_ST_IDLE = 2'b00,
      ATE_ST_RUN  = 2'b01,
      ATE_ST_HOLD = 2'b10
   } ate_state_t;

   typedef struct packed {
      logic [`ATE_NBITS-1:0]  bits;
      logic [`ATE_BUS_W-1:0]  bus_a;
      logic [`ATE_BUS_W-1:0]  bus_b;
      logic [`ATE_BUS_W-1:0]  bus_c;
      logic [`ATE_BUS_W-1:0]  bus_d;
      logic [`ATE_ADDR_W-1:0] iaddr;
   } ate_probe_t;

   typedef struct packed {
      ate_op_t                op;
      logic [`ATE_NODE_W-1:0] src_l;
      logic [`ATE_NODE_W-1:0] src_r;
      logic [`ATE_BUS_W-1:0]  konst;
   } ate_node_t;

   typedef struct packed {
      logic                                     advanced;
      logic [`ATE_NBITS-1:0][`ATE_COND_W-1:0]   bit_cond;
      logic [`ATE_BUS_W-1:0]                    bus_val;
      logic [`ATE_BUS_W-1:0]                    bus_care;
      logic                                     addr_en;
      logic [`ATE_ADDR_W-1:0]                   addr_val;
      logic [`ATE_NODES-1:0][$bits(ate_node_t)-1:0] nodes;
      logic [`ATE_NBITS-1:0]                    eld_sel;
      ate_cond_t                                eld_cond;
   } ate_cfg_t;

   typedef struct packed {
      ate_state_t  state;
      ate_probe_t  prev;
      logic        prev_ok;
      ate_probe_t  sample;
      logic        trig;
   } ate_regs_t;
endpackage

// ==== src/ate_evaluator.sv ====
`timescale 1ns/10ps
`include "ate_defs.svh"
module ate_evaluator (
   input  wire logic               i_core_clk,
   input  wire logic               i_rst_n,
   input  wire logic               i_start,
   input  wire logic               i_rearm,
   input  wire ate_pkg::ate_cfg_t  i_cfg,
   input  wire ate_pkg::ate_probe_t i_probe,
   output logic                    o_sample_valid,
   output ate_pkg::ate_probe_t     o_sample,
   output logic                    o_running,
   output logic                    o_triggered
);
   ate_pkg::ate_regs_t q;
   ate_pkg::ate_regs_t d;

   logic [`ATE_NBITS-1:0]  bit_ok;
   logic [`ATE_NBITS-1:0]  eld_ok;
   logic                   basic_hit;
   logic                   adv_hit;
   logic                   trig_now;
   wire logic [`ATE_NODES-1:0][`ATE_BUS_W-1:0] nv;

   // Bit match as one function so the basic terms and the detector operator agree.
   function automatic logic cond_match(input logic [`ATE_COND_W-1:0] c, input logic cur,
                                       input logic prv, input logic ok);
      case (c)
         ate_pkg::ATE_DONT_CARE: cond_match = 1'b1;
         ate_pkg::ATE_LOW:       cond_match = !cur;
         ate_pkg::ATE_HIGH:      cond_match = cur;
         ate_pkg::ATE_FALL:      cond_match = ok && prv && !cur;
         ate_pkg::ATE_RISE:      cond_match = ok && !prv && cur;
         ate_pkg::ATE_EITHER:    cond_match = ok && (prv != cur);
         // Unused codes never match, so a stray setting cannot fire a trigger.
         default:                cond_match = 1'b0;
      endcase
   endfunction

   genvar gi;
   generate
      for (gi = 0; gi < `ATE_NBITS; gi++) begin : g_bit
         assign bit_ok[gi] = cond_match(i_cfg.bit_cond[gi], i_probe.bits[gi], q.prev.bits[gi], q.prev_ok);
         assign eld_ok[gi] = !i_cfg.eld_sel[gi] ||
                             cond_match(i_cfg.eld_cond, i_probe.bits[gi], q.prev.bits[gi], q.prev_ok);
         AST_BIT_NO_HISTORY: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
            !q.prev_ok && (i_cfg.bit_cond[gi] inside {ate_pkg::ATE_FALL, ate_pkg::ATE_RISE, ate_pkg::ATE_EITHER})
            |-> !bit_ok[gi])
            else $error("Bit edge seen without history.");
      end
   endgenerate

   always_comb begin
      basic_hit = (&bit_ok)
                && (((i_probe.bus_a ^ i_cfg.bus_val) & i_cfg.bus_care) == '0)
                && (!i_cfg.addr_en || (i_probe.iaddr == i_cfg.addr_val));
   end

   // Nodes form a tree: node i may read only nodes of higher index, and node 0 is
   // the root. Reading upward keeps the tree free of loops; each extra level costs
   // one node stage of logic depth.
   // expression tree
   generate
      for (gi = 0; gi < `ATE_NODES; gi++) begin : g_node
         ate_pkg::ate_node_t    nd;
         logic [`ATE_BUS_W-1:0] l;
         logic [`ATE_BUS_W-1:0] r;
         logic [`ATE_BUS_W-1:0] val;
         assign nd = ate_pkg::ate_node_t'(i_cfg.nodes[gi]);
         assign l = (nd.src_l > `ATE_NODE_W'(gi)) ? nv[nd.src_l] : '0;
         assign r = (nd.src_r > `ATE_NODE_W'(gi)) ? nv[nd.src_r] : '0;
         assign nv[gi] = val;
         always_comb begin
            case (nd.op)
               ate_pkg::ATE_OP_BUS_A: val = i_probe.bus_a;
               ate_pkg::ATE_OP_BUS_B: val = i_probe.bus_b;
               ate_pkg::ATE_OP_BUS_C: val = i_probe.bus_c;
               ate_pkg::ATE_OP_BUS_D: val = i_probe.bus_d;
               ate_pkg::ATE_OP_CONST: val = nd.konst;
               ate_pkg::ATE_OP_LT:    val = `ATE_BUS_W'(l <  r);
               ate_pkg::ATE_OP_LE:    val = `ATE_BUS_W'(l <= r);
               ate_pkg::ATE_OP_EQ:    val = `ATE_BUS_W'(l == r);
               ate_pkg::ATE_OP_NE:    val = `ATE_BUS_W'(l != r);
               ate_pkg::ATE_OP_GT:    val = `ATE_BUS_W'(l >  r);
               ate_pkg::ATE_OP_GE:    val = `ATE_BUS_W'(l >= r);
               ate_pkg::ATE_OP_LNOT:  val = `ATE_BUS_W'(!(|l));
               ate_pkg::ATE_OP_LAND:  val = `ATE_BUS_W'((|l) && (|r));
               ate_pkg::ATE_OP_LOR:   val = `ATE_BUS_W'((|l) || (|r));
               ate_pkg::ATE_OP_LXOR:  val = `ATE_BUS_W'((|l) ^ (|r));
               ate_pkg::ATE_OP_RAND:  val = `ATE_BUS_W'(&l);
               ate_pkg::ATE_OP_ROR:   val = `ATE_BUS_W'(|l);
               ate_pkg::ATE_OP_RXOR:  val = `ATE_BUS_W'(^l);
               // Only the low four bits of the right operand count, so a shift stays within the bus.
               ate_pkg::ATE_OP_SHL:   val = l << r[3:0];
               ate_pkg::ATE_OP_SHR:   val = l >> r[3:0];
               ate_pkg::ATE_OP_BNOT:  val = ~l;
               ate_pkg::ATE_OP_BAND:  val = l & r;
               ate_pkg::ATE_OP_BOR:   val = l | r;
               ate_pkg::ATE_OP_BXOR:  val = l ^ r;
               ate_pkg::ATE_OP_EDGE:  val = `ATE_BUS_W'(&eld_ok);
               default:               val = '0;
            endcase
         end
      end
   endgenerate

   assign adv_hit  = |nv[0];
   assign trig_now = i_cfg.advanced ? adv_hit : basic_hit;

   always_comb begin
      d = q;
      d.trig = 1'b0;
      case (q.state)
         ate_pkg::ATE_ST_IDLE: begin
            // History is dropped here so that no edge is seen across a pause in sampling.
            d.prev_ok = 1'b0;
            if (i_start) begin
               d.state = ate_pkg::ATE_ST_RUN;
            end
         end
         ate_pkg::ATE_ST_RUN: begin
            d.sample  = i_probe;
            d.prev    = i_probe;
            d.prev_ok = 1'b1;
            if (trig_now) begin
               d.state = ate_pkg::ATE_ST_HOLD;
               d.trig  = 1'b1;
            end
         end
         ate_pkg::ATE_ST_HOLD: begin
            // The hold lasts until rearm, so later probe activity cannot overwrite the capture.
            if (i_rearm) begin
               d.state = ate_pkg::ATE_ST_IDLE;
            end
         end
         default: d.state = ate_pkg::ATE_ST_IDLE;
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_sample       = q.sample;
   assign o_sample_valid = (q.state == ate_pkg::ATE_ST_RUN);
   assign o_running      = (q.state == ate_pkg::ATE_ST_RUN);
   assign o_triggered    = (q.state == ate_pkg::ATE_ST_HOLD);

   // A trigger edge, the hold that must follow it, and the idle state.
   sequence seq_run_hit;
      o_running && trig_now;
   endsequence

   sequence seq_held;
      o_triggered ##1 (o_triggered || $past(i_rearm));
   endsequence

   sequence seq_idle;
      !o_running && !o_triggered;
   endsequence

   AST_HOLD_STABLE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      o_triggered && !i_rearm |=> o_triggered && $stable(o_sample))
      else $error("Sample changed while held.");
   AST_TRIG_PULSE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      seq_run_hit |=> q.trig ##1 !q.trig)
      else $error("Trigger flag did not pulse once.");
   AST_REARM_IDLE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      o_triggered && i_rearm |=> seq_idle)
      else $error("Rearm did not return to idle.");
   AST_START_RUN: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      seq_idle ##0 i_start |=> o_running && o_sample_valid)
      else $error("Start did not begin sampling.");
   AST_IDLE_QUIET: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      seq_idle ##0 !i_start |=> seq_idle ##0 $stable(o_sample))
      else $error("Idle state left without start.");
   AST_SAMPLE_FOLLOWS: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      o_running |=> o_sample == $past(i_probe))
      else $error("Probe not sampled.");
   AST_BASIC_STOP: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      o_running && !i_cfg.advanced && basic_hit |=> seq_held)
      else $error("Basic match did not trigger.");
   AST_NO_FALSE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      o_running && !trig_now |=> o_running)
      else $error("Stopped without match.");
   AST_BUS_MASK: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      ((i_probe.bus_a & i_cfg.bus_care) != (i_cfg.bus_val & i_cfg.bus_care)) |-> !basic_hit)
      else $error("Bus mismatch matched.");
   AST_ADDR: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_cfg.addr_en && (i_probe.iaddr != i_cfg.addr_val) |-> !basic_hit)
      else $error("Address mismatch matched.");
   AST_ADDR_HIT: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      o_running && !i_cfg.advanced && i_cfg.addr_en && (i_probe.iaddr == i_cfg.addr_val) && (&bit_ok)
      && (((i_probe.bus_a ^ i_cfg.bus_val) & i_cfg.bus_care) == '0) |=> o_triggered)
      else $error("Address match did not trigger.");
   AST_EDGE_PREV: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      !q.prev_ok && (i_cfg.eld_cond inside {ate_pkg::ATE_FALL, ate_pkg::ATE_RISE, ate_pkg::ATE_EITHER})
      |-> (eld_ok == ~i_cfg.eld_sel))
      else $error("Edge seen without history.");
   AST_ADV_STOP: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      o_running && i_cfg.advanced && adv_hit |=> seq_held)
      else $error("Advanced match did not trigger.");
endmodule // ate_evaluator

// ==== bench/ate_probe_model.sv ====
`timescale 1ns/10ps
module ate_probe_model (
   input  wire logic                i_core_clk,
   input  wire ate_pkg::ate_probe_t i_next,
   output ate_pkg::ate_probe_t      o_probe
);
   // Probed logic moves on the falling edge so every rising edge sees settled values.
   always_ff @(negedge i_core_clk) begin
      o_probe <= i_next;
   end
endmodule // ate_probe_model

// ==== bench/ate_evaluator_tb.sv ====
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module ate_evaluator_tb;
   logic                core_clk = 1'b0;
   logic                rst_n;
   logic                start;
   logic                rearm;
   ate_pkg::ate_cfg_t   cfg;
   ate_pkg::ate_probe_t nxt;
   ate_pkg::ate_probe_t probe;
   ate_pkg::ate_probe_t sample;
   logic                sample_valid;
   logic                running;
   logic                triggered;
   int                  failures = 0;
   int                  cmp_count = 0;

   ate_probe_model ate_probe_model_i (.i_core_clk(core_clk), .i_next(nxt), .o_probe(probe));
   ate_evaluator ate_evaluator_i (.i_core_clk(core_clk), .i_rst_n(rst_n), .i_start(start), .i_rearm(rearm),
      .i_cfg(cfg), .i_probe(probe), .o_sample_valid(sample_valid), .o_sample(sample),
      .o_running(running), .o_triggered(triggered));

   initial begin
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic results();
      $display("checks %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   function automatic ate_pkg::ate_node_t nd(ate_pkg::ate_op_t op, int l, int r);
      nd = '{op: op, src_l: 3'(l), src_r: 3'(r), konst: 16'h0000};
   endfunction

   task automatic drive(input ate_pkg::ate_probe_t p);
      nxt = p;
      @(negedge core_clk);
   endtask

   task automatic arm();
      start = 1'b1;
      @(negedge core_clk);
      start = 1'b0;
   endtask

   task automatic stop();
      rearm = 1'b1;
      @(negedge core_clk);
      rearm = 1'b0;
      @(negedge core_clk);
      `CHK("rearm_idle", 1'b0, running | triggered)
   endtask

   task automatic run(input ate_pkg::ate_cfg_t c, input ate_pkg::ate_probe_t idle, near, hit);
      int n;
      n = 0;
      cfg = c;
      drive(idle);
      arm();
      repeat (3) @(negedge core_clk);
      `CHK("running", 1'b1, running & sample_valid)
      `CHK("sample", idle, sample)
      drive(near);
      @(negedge core_clk);
      `CHK("near_miss", 1'b0, triggered)
      drive(hit);
      while (triggered !== 1'b1 && n < 3) begin
         @(negedge core_clk);
         n++;
      end
      `CHK("triggered", 1'b1, triggered & ~running)
      drive(idle);
      @(negedge core_clk);
      `CHK("frozen", hit, sample)
      stop();
   endtask

   task automatic cmp_ops();
      ate_pkg::ate_cfg_t   c;
      ate_pkg::ate_probe_t p;
      int                  first [6] = '{0, 0, 1, 0, 2, 1};
      for (int i = 0; i < 6; i++) begin
         c = '0;
         c.advanced = 1'b1;
         c.nodes[0] = nd(ate_pkg::ate_op_t'(5'(3 + i)), 1, 2);
         c.nodes[1] = nd(ate_pkg::ATE_OP_BUS_A, 0, 0);
         c.nodes[2] = nd(ate_pkg::ATE_OP_BUS_B, 0, 0);
         cfg = c;
         p = '0;
         p.bus_b = 16'h0005;
         p.bus_a = 16'h0003;
         drive(p);
         arm();
         for (int k = 0; k < 3; k++) begin
            p.bus_a = 16'(3 + 2 * k);
            drive(p);
            repeat (2) @(negedge core_clk);
            `CHK("compare", k >= first[i], triggered)
         end
         stop();
      end
   endtask

   task automatic tree_op(input ate_pkg::ate_op_t op, input logic [15:0] miss, hit, b, w);
      ate_pkg::ate_cfg_t   c;
      ate_pkg::ate_node_t  k;
      ate_pkg::ate_probe_t p;
      c = '0;
      c.advanced = 1'b1;
      k = nd(ate_pkg::ATE_OP_CONST, 0, 0);
      k.konst = w;
      c.nodes[0] = nd(ate_pkg::ATE_OP_EQ, 1, 2);
      c.nodes[1] = nd(op, 3, 4);
      c.nodes[2] = k;
      c.nodes[3] = nd(ate_pkg::ATE_OP_BUS_A, 0, 0);
      c.nodes[4] = nd(ate_pkg::ATE_OP_BUS_B, 0, 0);
      cfg = c;
      p = '0;
      p.bus_a = miss;
      p.bus_b = b;
      drive(p);
      arm();
      repeat (2) @(negedge core_clk);
      `CHK("tree_miss", 1'b0, triggered)
      p.bus_a = hit;
      drive(p);
      repeat (2) @(negedge core_clk);
      `CHK("tree_hit", 1'b1, triggered)
      stop();
   endtask

   // The whole sequence needs about 250 cycles; the limit leaves wide margin.
   initial begin
      #100000;
      failures++;
      results();
   end

   initial begin
      ate_pkg::ate_cfg_t   c;
      ate_pkg::ate_probe_t i0;
      ate_pkg::ate_probe_t n0;
      ate_pkg::ate_probe_t h0;
      rst_n = 1'b0;
      start = 1'b0;
      rearm = 1'b0;
      cfg = '0;
      nxt = '0;
      repeat (16) @(negedge core_clk);
      rst_n = 1'b1;
      `CHK("reset_idle", 1'b0, running | triggered | sample_valid)
      c = '0;
      c.bit_cond[0] = ate_pkg::ATE_RISE;
      c.bit_cond[1] = ate_pkg::ATE_HIGH;
      c.bit_cond[2] = ate_pkg::ATE_LOW;
      c.bit_cond[3] = ate_pkg::ATE_FALL;
      c.bit_cond[4] = ate_pkg::ATE_EITHER;
      c.bus_val = 16'h12A4;
      c.bus_care = 16'hFF0F;
      i0 = '0;
      i0.bits = 8'h0A;
      n0 = i0;
      n0.bus_a = 16'h12F4;
      h0 = n0;
      h0.bits = 8'h13;
      run(c, i0, n0, h0);
      c = '0;
      c.advanced = 1'b1;
      c.nodes[0] = nd(ate_pkg::ATE_OP_LAND, 1, 2);
      c.nodes[1] = nd(ate_pkg::ATE_OP_GE, 3, 4);
      c.nodes[2] = nd(ate_pkg::ATE_OP_EDGE, 0, 0);
      c.nodes[3] = nd(ate_pkg::ATE_OP_BUS_A, 0, 0);
      c.nodes[4] = nd(ate_pkg::ATE_OP_BUS_B, 0, 0);
      c.eld_sel = 8'h01;
      c.eld_cond = ate_pkg::ATE_RISE;
      i0 = '0;
      i0.bus_a = 16'h0005;
      i0.bus_b = 16'h0009;
      n0 = i0;
      n0.bus_a = 16'h0009;
      h0 = n0;
      h0.bits = 8'h01;
      run(c, i0, n0, h0);
      c.nodes[0] = nd(ate_pkg::ATE_OP_RAND, 1, 0);
      c.nodes[1] = nd(ate_pkg::ATE_OP_BAND, 2, 3);
      c.nodes[2] = nd(ate_pkg::ATE_OP_BUS_C, 0, 0);
      c.nodes[3] = nd(ate_pkg::ATE_OP_BUS_D, 0, 0);
      i0 = '0;
      i0.bus_c = 16'hFFFF;
      n0 = i0;
      n0.bus_d = 16'hFFFE;
      h0 = n0;
      h0.bus_d = 16'hFFFF;
      run(c, i0, n0, h0);
      c = '0;
      c.addr_en = 1'b1;
      c.addr_val = 32'h00004A10;
      i0 = '0;
      i0.iaddr = 32'h00004A0C;
      n0 = i0;
      n0.iaddr = 32'h00004A14;
      h0 = i0;
      h0.iaddr = 32'h00004A10;
      run(c, i0, n0, h0);
      cmp_ops();
      tree_op(ate_pkg::ATE_OP_SHL,  16'h0002, 16'h0003, 16'h0004, 16'h0030);
      tree_op(ate_pkg::ATE_OP_SHR,  16'h4000, 16'h8000, 16'h000F, 16'h0001);
      tree_op(ate_pkg::ATE_OP_BNOT, 16'h00FE, 16'h00FF, 16'h0000, 16'hFF00);
      tree_op(ate_pkg::ATE_OP_BOR,  16'h0E00, 16'h0F00, 16'h00F0, 16'h0FF0);
      tree_op(ate_pkg::ATE_OP_BXOR, 16'h0FFF, 16'h0FF0, 16'h00FF, 16'h0F0F);
      tree_op(ate_pkg::ATE_OP_LNOT, 16'h0010, 16'h0000, 16'h0000, 16'h0001);
      tree_op(ate_pkg::ATE_OP_LOR,  16'h0000, 16'h0100, 16'h0000, 16'h0001);
      tree_op(ate_pkg::ATE_OP_LXOR, 16'h0002, 16'h0000, 16'h0001, 16'h0001);
      tree_op(ate_pkg::ATE_OP_ROR,  16'h0000, 16'h0400, 16'h0000, 16'h0001);
      tree_op(ate_pkg::ATE_OP_RXOR, 16'h0003, 16'h0007, 16'h0000, 16'h0001);
      tree_op(ate_pkg::ATE_OP_RAND, 16'hFFFE, 16'hFFFF, 16'h0000, 16'h0001);
      results();
   end
endmodule // ate_evaluator_tb
